// >>> logic/asc_defines.svh
// Constants for the accelerometer scale and calibration register bank
// Assumes a 32-bit Avalon-MM slave with word addressing (byte addr = index * 4)
// Summary of operation
// RL1: Range code 000..100 selects 2g,4g,8g,16g,12g; 101..111 are reserved.
// RL2: Filter enable bit 3 zero bypasses the low-pass filter, one applies it.
// RL3: Bandwidth code 001,010,011,101 gives cutoff rate/4.255,/6,/12,/16; others reserved.
// RL4: Software always writes zero to bit 7 of the range control register.
// RL5: Output samples are sign-extended two's complement, scaled to the chosen range.
// RL6: Signed per-axis offset added to filter output; low byte bits 7:0, high 14:8.
// RL7: Offsets and gains load from OTP at reset and init; writes replace them.
// RL8: Each axis holds a 9-bit unsigned gain, low byte at consecutive addresses.
// RL9: Gain bit 8 is bit 7 of the axis offset high-byte register.
// RL10: Software uses read-modify-write to keep neighbouring bits unchanged; the bank here reads back zero except the status word.
// RL11: New settings take effect from the next sample, never mid-sample.
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// Register indices; byte address is index times four
`define ASC_IDX_CTRL      8'h20
`define ASC_IDX_X_OFFSET_VALUE_LO   8'h21
`define ASC_IDX_X_OFFSET_VALUE_HI   8'h22
`define ASC_IDX_Y_OFFSET_VALUE_LO   8'h23
`define ASC_IDX_Y_OFFSET_VALUE_HI   8'h24
`define ASC_IDX_Z_OFFSET_VALUE_LO   8'h25
`define ASC_IDX_Z_OFFSET_VALUE_HI   8'h26
`define ASC_IDX_X_GAIN_LOW     8'h27
`define ASC_IDX_Y_GAIN_LOW     8'h28
`define ASC_IDX_Z_GAIN_LOW     8'h29
// Extra status and command registers
`define ASC_IDX_STATUS    8'h30
`define ASC_IDX_INIT      8'h31

// Field positions of the control and offset high-byte registers
`define ASC_CTRL_RSV_BIT  7
`define ASC_RANGE_HI      6
`define ASC_RANGE_LO      4
`define ASC_LPEN_BIT      3
`define ASC_BW_HI         2
`define ASC_BW_LO         0
`define ASC_GAIN8_BIT     7
`define ASC_CTRL_RESET    8'h00

// Range codes
`define ASC_RANGE_2G      3'h0
`define ASC_RANGE_4G      3'h1
`define ASC_RANGE_8G      3'h2
`define ASC_RANGE_16G     3'h3
`define ASC_RANGE_12G     3'h4
// Bandwidth codes
`define ASC_BW_1          3'h1
`define ASC_BW_2          3'h2
`define ASC_BW_3          3'h3
`define ASC_BW_5          3'h5

// OTP image: 9 words of 8 bits, six offset bytes then three gain bytes packed
`define ASC_OTP_WORDS     4'h9
`define ASC_OTP_AW        4
`define ASC_RDATA_ZERO    32'h0000_0000
`endif

// >>> logic/asc_pkg.sv
// Types for the accelerometer scale and calibration register bank
// Assumes asc_defines.svh supplies every number
package asc_pkg;
  typedef enum logic [2:0] {
    ASC_FS_2G, ASC_FS_4G, ASC_FS_8G, ASC_FS_16G, ASC_FS_12G, ASC_FS_RSV
  } asc_range_t;
  typedef enum logic [2:0] {
    ASC_BWS_1, ASC_BWS_2, ASC_BWS_3, ASC_BWS_5, ASC_BWS_RSV
  } asc_bw_t;
  typedef enum logic [1:0] {
    ASC_ST_LOAD, ASC_ST_WAIT, ASC_ST_RUN
  } asc_state_t;
endpackage

// >>> logic/asc_otp_rom.sv
// One-time-programmable calibration memory model, registered read data
// Assumes contents are fused at manufacture; values here are arbitrary defaults
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_otp_rom (
  input  wire logic                    ref_clk_i,
  input  wire logic [`ASC_OTP_AW-1:0]  addr_i,
  output logic      [7:0]              data_o
);
  logic [7:0] data_q;
  logic [7:0] data_d;

  // Arbitrary fused image: zero offsets, gain of 256
  always_comb begin
    case (addr_i)
      4'h1:    data_d = 8'h80;
      4'h3:    data_d = 8'h80;
      4'h5:    data_d = 8'h80;
      default: data_d = 8'h00;
    endcase
  end

  // Registered read port
  always_ff @(posedge ref_clk_i) begin
    data_q <= data_d;
  end

  assign data_o = data_q;
endmodule

// >>> logic/asc_sample_gate.sv
// Holds applied settings and refreshes them only at a sample boundary
// Assumes sample_start_i pulses once as each new sample begins
`timescale 1ns/1ps
module asc_sample_gate #(
  parameter int W = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         sample_start_i,
  input  wire logic [W-1:0] shadow_i,
  output logic      [W-1:0] applied_o
);
  logic [W-1:0] app_q;
  logic [W-1:0] app_d;

  // Take the shadow copy only as a sample starts
  always_comb begin
    app_d = app_q;
    if (sample_start_i) begin
      app_d = shadow_i; // [RL11]
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      app_q <= '0;
    end else begin
      app_q <= app_d;
    end
  end

  assign applied_o = app_q;
endmodule

// >>> logic/asc_regs.sv
// Accelerometer scale, filter and calibration register bank
// Assumes Avalon-MM master on ref_clk_i, word addresses, 32-bit data
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "asc_defines.svh"
module asc_regs (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  input  wire logic        sample_start_i,
  output logic      [2:0]  full_scale_o,
  output logic      [4:0]  scale_shift_o,
  output logic             range_valid_o,
  output logic             lowpass_enable_o,
  output logic      [2:0]  lowpass_bandwidth_o,
  output logic      [3:0]  bw_divisor_sel_o,
  output logic             bw_valid_o,
  output logic      [14:0] x_offset_value_o,
  output logic      [14:0] y_offset_value_o,
  output logic      [14:0] z_offset_value_o,
  output logic      [8:0]  x_gain_value_o,
  output logic      [8:0]  y_gain_value_o,
  output logic      [8:0]  z_gain_value_o,
  output logic             calib_loaded_o
);
  // Shadow registers written by software or OTP
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  off_lo_q [3], off_lo_d [3];
  logic [7:0]  off_hi_q [3], off_hi_d [3];
  logic [7:0]  gain_q [3], gain_d [3];
  asc_pkg::asc_state_t st_q, st_d;
  logic [`ASC_OTP_AW-1:0] ptr_q, ptr_d;
  logic [`ASC_OTP_AW-1:0] rd_ptr_q, rd_ptr_d;
  logic [7:0]  otp_data;
  logic        wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  resp_q, resp_d;
  logic        load_flag_q, load_flag_d;
  logic [7:0]  ctrl_app;
  logic [71:0] cal_app;

  // Range code to output scale shift
  function automatic logic [4:0] range_shift(input logic [2:0] c);
    case (c)
      `ASC_RANGE_2G:  range_shift = 5'h0;
      `ASC_RANGE_4G:  range_shift = 5'h1;
      `ASC_RANGE_8G:  range_shift = 5'h2;
      `ASC_RANGE_16G: range_shift = 5'h3;
      `ASC_RANGE_12G: range_shift = 5'h4;
      default:        range_shift = 5'h1f;
    endcase
  endfunction

  // Bandwidth code to cutoff divisor index
  function automatic logic [3:0] bw_sel(input logic [2:0] c);
    case (c)
      `ASC_BW_1: bw_sel = 4'h1;
      `ASC_BW_2: bw_sel = 4'h2;
      `ASC_BW_3: bw_sel = 4'h3;
      `ASC_BW_5: bw_sel = 4'h5;
      default:   bw_sel = 4'h0;
    endcase
  endfunction

  // Word index that holds a writable register
  function automatic logic idx_mapped(input logic [7:0] a);
    idx_mapped = ((a >= `ASC_IDX_CTRL) && (a <= `ASC_IDX_Z_GAIN_LOW)) || (a == `ASC_IDX_INIT);
  endfunction

  asc_otp_rom u_otp (
    .ref_clk_i (ref_clk_i),
    .addr_i    (ptr_q),
    .data_o    (otp_data)
  );

  // OTP load sequencer and register writes
  always_comb begin
    st_d        = st_q;
    ptr_d       = ptr_q;
    rd_ptr_d    = ptr_q;
    ctrl_d      = ctrl_q;
    off_lo_d    = off_lo_q;
    off_hi_d    = off_hi_q;
    gain_d      = gain_q;
    load_flag_d = load_flag_q;
    wait_d      = 1'b1;
    rdata_d     = `ASC_RDATA_ZERO;
    resp_d      = 2'h0;
    case (st_q)
      asc_pkg::ASC_ST_LOAD: begin
        // One OTP word per cycle; data lags address by a cycle
        ptr_d = ptr_q + 4'h1;
        st_d  = asc_pkg::ASC_ST_WAIT;
      end
      asc_pkg::ASC_ST_WAIT: begin
        case (rd_ptr_q)
          4'h0: off_lo_d[0] = otp_data; // [RL7]
          4'h1: off_hi_d[0] = otp_data;
          4'h2: off_lo_d[1] = otp_data;
          4'h3: off_hi_d[1] = otp_data;
          4'h4: off_lo_d[2] = otp_data;
          4'h5: off_hi_d[2] = otp_data;
          4'h6: gain_d[0]   = otp_data;
          4'h7: gain_d[1]   = otp_data;
          default: gain_d[2] = otp_data;
        endcase
        if (rd_ptr_q == `ASC_OTP_WORDS - 4'h1) begin
          st_d        = asc_pkg::ASC_ST_RUN;
          load_flag_d = 1'b1;
          ptr_d       = '0;
        end else begin
          ptr_d = ptr_q + 4'h1;
        end
        rd_ptr_d = ptr_q;
      end
      asc_pkg::ASC_ST_RUN: begin
        // First cycle prepares the answer; nothing is committed yet
        if ((avs_read || avs_write) && avs_waitrequest) begin
          wait_d = 1'b0;
          if (avs_write && avs_byteenable[0] && !idx_mapped(avs_address)) begin
            resp_d = 2'h3;
          end else if (avs_read) begin
            // Bank is write-only; status word shows load state
            if (avs_address == `ASC_IDX_STATUS) begin
              rdata_d = {31'h0000_0000, load_flag_q};
            end
          end
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
          // Write lands at the handshake edge only
          case (avs_address)
            `ASC_IDX_CTRL:    ctrl_d = avs_writedata[7:0]; // [RL1] [RL2] [RL3]
            `ASC_IDX_X_OFFSET_VALUE_LO: off_lo_d[0] = avs_writedata[7:0]; // [RL6]
            `ASC_IDX_X_OFFSET_VALUE_HI: off_hi_d[0] = avs_writedata[7:0]; // [RL9]
            `ASC_IDX_Y_OFFSET_VALUE_LO: off_lo_d[1] = avs_writedata[7:0];
            `ASC_IDX_Y_OFFSET_VALUE_HI: off_hi_d[1] = avs_writedata[7:0];
            `ASC_IDX_Z_OFFSET_VALUE_LO: off_lo_d[2] = avs_writedata[7:0];
            `ASC_IDX_Z_OFFSET_VALUE_HI: off_hi_d[2] = avs_writedata[7:0];
            `ASC_IDX_X_GAIN_LOW:   gain_d[0] = avs_writedata[7:0]; // [RL8]
            `ASC_IDX_Y_GAIN_LOW:   gain_d[1] = avs_writedata[7:0];
            `ASC_IDX_Z_GAIN_LOW:   gain_d[2] = avs_writedata[7:0];
            `ASC_IDX_INIT: begin
              if (avs_writedata[0]) begin
                st_d        = asc_pkg::ASC_ST_LOAD; // [RL7]
                ptr_d       = '0;
                load_flag_d = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
      default: st_d = asc_pkg::ASC_ST_LOAD;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      st_q        <= asc_pkg::ASC_ST_LOAD;
      ptr_q       <= '0;
      rd_ptr_q    <= '0;
      ctrl_q      <= `ASC_CTRL_RESET;
      off_lo_q    <= '{default: 8'h00};
      off_hi_q    <= '{default: 8'h00};
      gain_q      <= '{default: 8'h00};
      load_flag_q <= 1'b0;
      wait_q      <= 1'b1;
      rdata_q     <= `ASC_RDATA_ZERO;
      resp_q      <= 2'h0;
    end else begin
      st_q        <= st_d;
      ptr_q       <= ptr_d;
      rd_ptr_q    <= rd_ptr_d;
      ctrl_q      <= ctrl_d;
      off_lo_q    <= off_lo_d;
      off_hi_q    <= off_hi_d;
      gain_q      <= gain_d;
      load_flag_q <= load_flag_d;
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
      resp_q      <= resp_d;
    end
  end

  // Settings move to the datapath only at sample boundaries
  asc_sample_gate #(.W(8)) u_ctrl_gate (
    .ref_clk_i      (ref_clk_i),
    .rstn_i         (rstn_i),
    .sample_start_i (sample_start_i),
    .shadow_i       (ctrl_q),
    .applied_o      (ctrl_app)
  );

  asc_sample_gate #(.W(72)) u_cal_gate (
    .ref_clk_i      (ref_clk_i),
    .rstn_i         (rstn_i),
    .sample_start_i (sample_start_i && load_flag_q),
    .shadow_i       ({off_hi_q[2], off_lo_q[2], off_hi_q[1], off_lo_q[1],
                      off_hi_q[0], off_lo_q[0], gain_q[2], gain_q[1], gain_q[0]}),
    .applied_o      (cal_app)
  );

  // Decoded output register stage
  logic [2:0]  fs_q;
  logic [4:0]  sh_q;
  logic        rv_q, lpe_q, bwv_q;
  logic [2:0]  bw_q;
  logic [3:0]  bws_q;
  logic [14:0] xo_q, yo_q, zo_q;
  logic [8:0]  xg_q, yg_q, zg_q;
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      fs_q  <= '0;
      sh_q  <= '0;
      rv_q  <= 1'b1;
      lpe_q <= 1'b0;
      bw_q  <= '0;
      bws_q <= '0;
      bwv_q <= 1'b0;
      xo_q  <= '0;
      yo_q  <= '0;
      zo_q  <= '0;
      xg_q  <= '0;
      yg_q  <= '0;
      zg_q  <= '0;
    end else begin
      fs_q  <= ctrl_app[`ASC_RANGE_HI:`ASC_RANGE_LO];
      sh_q  <= range_shift(ctrl_app[`ASC_RANGE_HI:`ASC_RANGE_LO]); // [RL1] [RL5]
      rv_q  <= range_shift(ctrl_app[`ASC_RANGE_HI:`ASC_RANGE_LO]) != 5'h1f;
      lpe_q <= ctrl_app[`ASC_LPEN_BIT]; // [RL2]
      bw_q  <= ctrl_app[`ASC_BW_HI:`ASC_BW_LO];
      bws_q <= bw_sel(ctrl_app[`ASC_BW_HI:`ASC_BW_LO]); // [RL3]
      bwv_q <= bw_sel(ctrl_app[`ASC_BW_HI:`ASC_BW_LO]) != 4'h0;
      // Offset is 15 bits: high byte bits 6:0 over low byte [RL6]
      xo_q  <= {cal_app[38:32], cal_app[31:24]};
      yo_q  <= {cal_app[54:48], cal_app[47:40]};
      zo_q  <= {cal_app[70:64], cal_app[63:56]};
      // Gain bit 8 from the offset high byte bit 7 [RL8] [RL9]
      xg_q  <= {cal_app[39], cal_app[7:0]};
      yg_q  <= {cal_app[55], cal_app[15:8]};
      zg_q  <= {cal_app[71], cal_app[23:16]};
    end
  end

  assign avs_readdata        = rdata_q;
  assign avs_waitrequest     = wait_q;
  assign avs_response        = resp_q;
  assign full_scale_o        = fs_q;
  assign scale_shift_o       = sh_q;
  assign range_valid_o       = rv_q;
  assign lowpass_enable_o    = lpe_q;
  assign lowpass_bandwidth_o = bw_q;
  assign bw_divisor_sel_o    = bws_q;
  assign bw_valid_o          = bwv_q;
  assign x_offset_value_o    = xo_q;
  assign y_offset_value_o    = yo_q;
  assign z_offset_value_o    = zo_q;
  assign x_gain_value_o      = xg_q;
  assign y_gain_value_o      = yg_q;
  assign z_gain_value_o      = zg_q;
  assign calib_loaded_o      = load_flag_q;

  // A control write reaches the decoded outputs only after a sample start
  AST_CTRL_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    !sample_start_i |=> $stable(ctrl_app))
    else $error("control changed without sample start"); // [RL11]

  // Filter enable output follows the applied bit 3
  AST_LPEN: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    1'b1 |=> lowpass_enable_o == $past(ctrl_app[`ASC_LPEN_BIT]))
    else $error("filter enable mismatch"); // [RL2]

  // Reserved range codes flag invalid
  AST_RANGE_RSV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    ctrl_app[6:4] > 3'h4 |=> !range_valid_o)
    else $error("reserved range accepted"); // [RL1]

  // Reserved bandwidth codes flag invalid
  AST_BW_RSV: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (ctrl_app[2:0] == 3'h0 || ctrl_app[2:0] == 3'h4 || ctrl_app[2:0] > 3'h5) |=> !bw_valid_o)
    else $error("reserved bandwidth accepted"); // [RL3]

  // Gain msb tracks offset high byte bit 7
  AST_GAIN_MSB: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    1'b1 |=> x_gain_value_o[8] == $past(cal_app[39]))
    else $error("gain bit 8 wrong"); // [RL9]

  // Offset is the two bytes joined
  AST_OFFSET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    1'b1 |=> y_offset_value_o == $past({cal_app[54:48], cal_app[47:40]}))
    else $error("offset join wrong"); // [RL6]

  // OTP load completes within bounded cycles of reset
  AST_LOAD_DONE: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    st_q == asc_pkg::ASC_ST_LOAD |-> ##[1:30] load_flag_q)
    else $error("calibration load stalled"); // [RL7]

  // Gain low byte write lands
  AST_GAIN_WR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
    (st_q == asc_pkg::ASC_ST_RUN && avs_write && !avs_waitrequest && avs_byteenable[0]
     && avs_address == `ASC_IDX_Z_GAIN_LOW) |=> gain_q[2] == $past(avs_writedata[7:0]))
    else $error("gain write lost"); // [RL8]
endmodule

// >>> sim/tb_asc_regs.sv
// Self-checking bench for the scale and calibration register bank
// Assumes the bank alone on one 125 MHz clock, reached over Avalon-MM
`timescale 1ns/1ps
module tb_asc_regs;
  logic        ref_clk_i      = 1'b0;
  logic        rstn_i         = 1'b0;
  logic [7:0]  avs_address    = 8'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        sample_start_i = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [1:0]  avs_response;
  logic [2:0]  full_scale_o;
  logic [4:0]  scale_shift_o;
  logic        range_valid_o;
  logic        lowpass_enable_o;
  logic [2:0]  lowpass_bandwidth_o;
  logic [3:0]  bw_divisor_sel_o;
  logic        bw_valid_o;
  logic [14:0] x_offset_value_o;
  logic [14:0] y_offset_value_o;
  logic [14:0] z_offset_value_o;
  logic [8:0]  x_gain_value_o;
  logic [8:0]  y_gain_value_o;
  logic [8:0]  z_gain_value_o;
  logic        calib_loaded_o;
  // Bench model of the written registers and expectation queues
  logic [7:0]  ctrl_m;
  logic [7:0]  lo_m [3];
  logic [7:0]  hi_m [3];
  logic [7:0]  gn_m [3];
  logic [89:0] applied;
  logic [31:0] rs = 32'd94;
  logic [33:0] bus_q [$];
  logic [89:0] set_q [$];
  int          err_total   = 0;
  int          check_count = 0;

  asc_regs asc_regs_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .sample_start_i(sample_start_i), .full_scale_o(full_scale_o),
    .scale_shift_o(scale_shift_o), .range_valid_o(range_valid_o),
    .lowpass_enable_o(lowpass_enable_o), .lowpass_bandwidth_o(lowpass_bandwidth_o),
    .bw_divisor_sel_o(bw_divisor_sel_o), .bw_valid_o(bw_valid_o),
    .x_offset_value_o(x_offset_value_o), .y_offset_value_o(y_offset_value_o),
    .z_offset_value_o(z_offset_value_o), .x_gain_value_o(x_gain_value_o),
    .y_gain_value_o(y_gain_value_o), .z_gain_value_o(z_gain_value_o),
    .calib_loaded_o(calib_loaded_o)
  );

  // Clock, 8 ns period
  always #4 ref_clk_i = ~ref_clk_i;

  // Xorshift source for calibration bytes
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction

  // Applied settings as one vector
  function automatic logic [89:0] got();
    return {full_scale_o, scale_shift_o, range_valid_o, lowpass_enable_o,
            lowpass_bandwidth_o, bw_divisor_sel_o, bw_valid_o, x_offset_value_o,
            y_offset_value_o, z_offset_value_o, x_gain_value_o, y_gain_value_o,
            z_gain_value_o};
  endfunction

  // Expected settings from the register model
  function automatic logic [89:0] exp_snap();
    logic [2:0] r;
    logic [2:0] b;
    logic       bv;
    r  = ctrl_m[6:4];
    b  = ctrl_m[2:0];
    bv = (b == 3'h1) || (b == 3'h2) || (b == 3'h3) || (b == 3'h5);
    return {r, (r <= 3'h4) ? {2'b00, r} : 5'h1f, r <= 3'h4, ctrl_m[3], b,
            bv ? {1'b0, b} : 4'h0, bv,
            hi_m[0][6:0], lo_m[0], hi_m[1][6:0], lo_m[1], hi_m[2][6:0], lo_m[2],
            hi_m[0][7], gn_m[0], hi_m[1][7], gn_m[1], hi_m[2][7], gn_m[2]};
  endfunction

  // Calibration values as loaded from the one-time memory
  task automatic otp_model();
    for (int k = 0; k < 3; k++) begin
      lo_m[k] = 8'h00;
      hi_m[k] = 8'h80;
      gn_m[k] = 8'h00;
    end
  endtask

  task automatic cmp_bus(input string nm, input logic [33:0] ex, input logic [33:0] gt);
    check_count++;
    if (gt !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h got %h", nm, ex, gt);
    end
  endtask

  task automatic cmp_set(input string nm, input logic [89:0] ex, input logic [89:0] gt);
    check_count++;
    if (gt !== ex) begin
      err_total++;
      $display("[ERR] %s expected %h got %h", nm, ex, gt);
    end
  endtask

  // One Avalon access; answer expectation noted before it starts
  task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be,
                     input logic wr, input logic [33:0] ex);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address    <= a;
    avs_writedata  <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    bus_q.push_back(ex);
    @(posedge ref_clk_i);
    while (avs_waitrequest !== 1'b0 && n < 300) begin
      n++;
      @(posedge ref_clk_i);
    end
    if (n >= 300)
      cmp_bus("waitrequest", 34'h0, {32'h0, 2'b11});
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Register write that also updates the bench model
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    bus(a, d, 4'h1, 1'b1, 34'h0);
    case (a)
      8'h20: ctrl_m = d;
      8'h21, 8'h23, 8'h25: lo_m[(a - 8'h21) >> 1] = d;
      8'h22, 8'h24, 8'h26: hi_m[(a - 8'h22) >> 1] = d;
      8'h27, 8'h28, 8'h29: gn_m[a - 8'h27] = d;
      8'h31: otp_model();
      default: ;
    endcase
  endtask

  // Sample boundary: note the settings that must appear
  task automatic pulse();
    @(posedge ref_clk_i);
    sample_start_i <= 1'b1;
    applied = exp_snap();
    set_q.push_back(applied);
    @(posedge ref_clk_i);
    sample_start_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask

  // Reset, wait out the load, check defaults
  task automatic do_reset();
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    ctrl_m = 8'h00;
    otp_model();
    bus(8'h30, 8'h00, 4'h1, 1'b0, {32'h1, 2'b00});
    pulse();
    $display("test reset done, errors %0d", err_total);
  endtask

  // Bus answer watcher
  always @(posedge ref_clk_i) begin
    if (rstn_i && avs_waitrequest === 1'b0) begin
      if (bus_q.size() > 0)
        cmp_bus("bus answer", bus_q.pop_front(), {avs_readdata, avs_response});
      else
        cmp_bus("bus answer", 34'h0, 34'h3_ffff_ffff);
    end
  end

  // Settings watcher, two edges after each sample boundary
  initial forever begin
    @(posedge ref_clk_i);
    if (rstn_i && sample_start_i === 1'b1) begin
      repeat (2) @(posedge ref_clk_i);
      if (set_q.size() > 0)
        cmp_set("settings", set_q.pop_front(), got());
    end
  end

  task finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    $display("[ERR] watchdog expected done got timeout");
    finish_test;
  end

  // Main sequence
  initial begin
    do_reset();
    bus(8'h22, 8'h00, 4'h1, 1'b0, 34'h0);
    bus(8'h3f, 8'h5a, 4'h1, 1'b1, {32'h0, 2'b11});
    pulse();
    $display("test access done, errors %0d", err_total);
    for (int i = 0; i < 8; i++) begin
      wreg(8'h20, {1'b0, i[2:0], i[0], i[2:0]});
      cmp_set("held", applied, got());
      pulse();
    end
    $display("test range done, errors %0d", err_total);
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 3; k++) begin
        wreg(8'h21 + 8'(2 * k), rnd());
        wreg(8'h22 + 8'(2 * k), rnd());
        wreg(8'h27 + 8'(k), rnd());
      end
      bus(8'h27, rnd(), 4'h0, 1'b1, 34'h0);
      cmp_set("held", applied, got());
      pulse();
    end
    wreg(8'h22, hi_m[0] ^ 8'h80);
    pulse();
    $display("test calibration done, errors %0d", err_total);
    wreg(8'h31, 8'h01);
    repeat (2) @(posedge ref_clk_i);
    cmp_bus("loaded", 34'h0, {33'h0, calib_loaded_o});
    for (int n = 0; n < 200 && calib_loaded_o !== 1'b1; n++)
      @(posedge ref_clk_i);
    cmp_bus("loaded", 34'h1, {33'h0, calib_loaded_o});
    bus(8'h30, 8'h00, 4'h1, 1'b0, {32'h1, 2'b00});
    pulse();
    $display("test reload done, errors %0d", err_total);
    wreg(8'h25, rnd());
    do_reset();
    finish_test;
  end
endmodule
